// ===== verification/pcde_board.sv
// board-side model: resolves each port pin from device and external drivers
`timescale 1ns/1ns
module pcde_board #(
  parameter int W = 8
) (
  // device side
  input wire logic [W-1:0] i_dev_val,
  input wire logic [W-1:0] i_dev_oe,
  // external driver
  input wire logic [W-1:0] i_ext_val,
  input wire logic [W-1:0] i_ext_en,
  // level seen by the device
  output logic [W-1:0] o_level
);
  // ****
  // pin resolution
  // ****
  // undriven pins sit on a pull-up, so idle strobes read high
  always_comb begin
    for (int k = 0; k < W; k++) begin
      o_level[k] = i_dev_oe[k] ? i_dev_val[k] : (i_ext_en[k] ? i_ext_val[k] : 1'b1);
    end
  end
endmodule // pcde_board

// ===== verification/pcde_io_checker.sv
// port-level assertions for the port c/d/e io block
`timescale 1ns/1ns
module pcde_io_checker (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // port c and peripherals
  input wire logic [7:0] i_port_c_per_sel,
  input wire logic [7:0] i_port_c_per_out,
  input wire logic [7:0] i_port_c_per_oe,
  input wire logic [7:0] i_port_c_per_force_in,
  input wire logic i_serial_i2c_mode,
  input wire logic [7:0] o_port_c_pin,
  input wire logic [7:0] o_port_c_oe,
  input wire logic [1:0] o_port_c_smbus_lvl,
  // port d, port e and parallel view
  input wire logic [7:0] i_port_d_pin,
  input wire logic [7:0] o_port_d_oe,
  input wire logic o_port_d_ttl,
  input wire logic o_port_e_ttl,
  input wire logic o_par_mode,
  input wire logic o_par_rd_n,
  input wire logic o_par_wr_n,
  input wire logic o_par_cs_n,
  input wire logic [7:0] o_par_data_in
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  // past guards keep reset-time inputs from judging the first edge
  force_in_wins_a: assert property (
    $past(i_rst_n) |-> (o_port_c_oe & $past(i_port_c_per_force_in)) == 8'h00)
    else $error("forced input pin still driven");
  per_data_a: assert property (
    $past(i_rst_n) |-> ((o_port_c_pin ^ $past(i_port_c_per_out)) & $past(i_port_c_per_sel)
      & ~$past(i_port_c_per_force_in)) == 8'h00)
    else $error("selected pin not carrying peripheral data");
  per_oe_a: assert property (
    $past(i_rst_n) |-> ((o_port_c_oe ^ $past(i_port_c_per_oe)) & $past(i_port_c_per_sel)
      & ~$past(i_port_c_per_force_in)) == 8'h00)
    else $error("selected pin enable not from peripheral");
  smbus_off_a: assert property (
    !$past(i_serial_i2c_mode) |-> o_port_c_smbus_lvl == 2'b00)
    else $error("smbus levels outside i2c mode");
  ttl_mode_a: assert property (
    (o_port_d_ttl == o_par_mode) && (o_port_e_ttl == o_par_mode))
    else $error("ttl buffers do not follow parallel mode");
  strobe_idle_a: assert property (
    !o_par_mode && !$past(o_par_mode) |-> {o_par_cs_n, o_par_wr_n, o_par_rd_n} == 3'b111)
    else $error("strobes not idle outside parallel mode");
  par_drive_a: assert property (
    (o_par_mode && !o_par_rd_n && !o_par_cs_n) [*3] |-> o_port_d_oe == 8'hff)
    else $error("port d not driven during parallel read");
  par_float_a: assert property (
    (o_par_mode && o_par_rd_n) [*3] |-> o_port_d_oe == 8'h00)
    else $error("port d driven while read strobe idle");
  // pin to output is two synchroniser flops plus the output flop: three edges
  par_data_a: assert property (
    o_par_mode && $past(i_rst_n) && $past(i_rst_n, 3) |-> o_par_data_in == $past(i_port_d_pin, 3))
    else $error("parallel data bit order wrong");
endmodule // pcde_io_checker
bind pcde_io pcde_io_checker pcde_io_checker_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_port_c_per_sel(i_port_c_per_sel), .i_port_c_per_out(i_port_c_per_out),
  .i_port_c_per_oe(i_port_c_per_oe), .i_port_c_per_force_in(i_port_c_per_force_in),
  .i_serial_i2c_mode(i_serial_i2c_mode), .o_port_c_pin(o_port_c_pin),
  .o_port_c_oe(o_port_c_oe), .o_port_c_smbus_lvl(o_port_c_smbus_lvl),
  .i_port_d_pin(i_port_d_pin), .o_port_d_oe(o_port_d_oe), .o_port_d_ttl(o_port_d_ttl),
  .o_port_e_ttl(o_port_e_ttl), .o_par_mode(o_par_mode), .o_par_rd_n(o_par_rd_n),
  .o_par_wr_n(o_par_wr_n), .o_par_cs_n(o_par_cs_n), .o_par_data_in(o_par_data_in));

// ===== verification/pcde_io_tb.sv
// self-checking testbench for the port c/d/e io block
`timescale 1ns/1ns
`include "pcde_cfg.svh"
module pcde_io_tb;
  import pcde_pkg::*;
  // ****
  // signals and instances
  // ****
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0, i_i2c = 1'b0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, rdv;
  logic [1:0] i_htrans = 2'b00, o_smb;
  logic [2:0] i_hsize = 3'b010, e_val = 3'b111, e_en = 3'b000, e_in, e_out, e_oe;
  logic o_hreadyout, o_hresp, o_d_ttl, o_e_ttl, o_mode, o_rd_n, o_wr_n, o_cs_n;
  pcde_byte_t c_val = 8'h00, c_en = 8'h00, d_val = 8'h00, d_en = 8'h00, c_in, d_in, c_pi;
  pcde_byte_t sel = 8'h00, pout = 8'h00, poe = 8'h00, fin = 8'h00, c_out, c_oe, d_out, d_oe, pd;
  int fails = 0, checks = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  pcde_io pcde_io_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_port_c_pin(c_in), .o_port_c_pin(c_out),
    .o_port_c_oe(c_oe), .o_port_c_smbus_lvl(o_smb), .i_port_c_per_sel(sel),
    .i_port_c_per_out(pout), .i_port_c_per_oe(poe), .i_port_c_per_force_in(fin),
    .i_serial_i2c_mode(i_i2c), .o_port_c_per_in(c_pi), .i_port_d_pin(d_in), .o_port_d_pin(d_out),
    .o_port_d_oe(d_oe), .o_port_d_ttl(o_d_ttl), .i_port_e_pin(e_in), .o_port_e_pin(e_out),
    .o_port_e_oe(e_oe), .o_port_e_ttl(o_e_ttl), .o_par_mode(o_mode), .o_par_rd_n(o_rd_n),
    .o_par_wr_n(o_wr_n), .o_par_cs_n(o_cs_n), .o_par_data_in(pd));
  pcde_board #(.W(8)) pcde_board_c_i (.i_dev_val(c_out), .i_dev_oe(c_oe), .i_ext_val(c_val),
    .i_ext_en(c_en), .o_level(c_in));
  pcde_board #(.W(8)) pcde_board_d_i (.i_dev_val(d_out), .i_dev_oe(d_oe), .i_ext_val(d_val),
    .i_ext_en(d_en), .o_level(d_in));
  pcde_board #(.W(3)) pcde_board_e_i (.i_dev_val(e_out), .i_dev_oe(e_oe), .i_ext_val(e_val),
    .i_ext_en(e_en), .o_level(e_in));
  // ****
  // bus and compare tasks
  // ****
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    checks++;
    if (act !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  // one ahb-lite single word transfer; each phase is held until hready is sampled
  // high at a rising edge, and read data is taken at the edge ending the data phase
  task automatic bus(input logic wr, input pcde_byte_t idx, input pcde_byte_t wd);
    @(posedge i_clk_sys);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_hwrite <= wr;
    i_haddr <= {22'h0, idx, 2'b00};
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= {24'h0, wd};
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    rdv = o_hrdata;
  endtask
  task automatic rd(input pcde_byte_t idx, input pcde_byte_t exp);
    bus(1'b0, idx, 8'h00);
    chk(rdv, {24'h0, exp});
  endtask
  // pins settle two edges after a change; sample away from the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rd(`PCDE_IDX_C_DIR, 8'hff);
    rd(`PCDE_IDX_D_DIR, 8'hff);
    rd(`PCDE_IDX_E_DIR, 8'h07);
    rd(`PCDE_IDX_E_DATA, 8'h00);
    rd(8'h20, 8'h00);
    tick(0);
    chk(c_oe, 0);
    chk({o_hreadyout, o_hresp}, 2'b10);
    $display("reset values done");
    @(posedge i_clk_sys);
    c_en <= 8'hff;
    c_val <= 8'hc3;
    bus(1'b1, `PCDE_IDX_C_DATA, 8'h5a);
    bus(1'b1, `PCDE_IDX_C_DIR, 8'h0f);
    tick(3);
    chk(c_oe, 8'hf0);
    chk(c_out & 8'hf0, 8'h50);
    rd(`PCDE_IDX_C_DATA, 8'h53);
    bus(1'b1, `PCDE_IDX_C_DATA, 8'h00);
    tick(3);
    rd(`PCDE_IDX_C_DATA, 8'h03);
    sel <= 8'h03;
    pout <= 8'h01;
    poe <= 8'h03;
    tick(2);
    chk(c_oe, 8'hf3);
    chk(c_out & 8'h03, 8'h01);
    bus(1'b1, `PCDE_IDX_C_DIR, 8'h0f);
    tick(2);
    chk(c_oe, 8'hf3);
    @(posedge i_clk_sys);
    fin <= 8'h02;
    tick(2);
    chk(c_oe, 8'hf1);
    @(posedge i_clk_sys);
    sel <= 8'h00;
    tick(2);
    chk(c_oe, 8'hf0);
    bus(1'b1, `PCDE_IDX_SER_STAT, 8'h40);
    i_i2c <= 1'b1;
    tick(2);
    chk(o_smb, 2'b11);
    bus(1'b1, `PCDE_IDX_SER_STAT, 8'h00);
    tick(2);
    chk(o_smb, 2'b00);
    chk(c_pi, 8'h03);
    $display("port c done");
    bus(1'b1, `PCDE_IDX_D_DIR, 8'h00);
    bus(1'b1, `PCDE_IDX_D_DATA, 8'ha5);
    tick(3);
    chk(d_oe, 8'hff);
    chk(d_out, 8'ha5);
    rd(`PCDE_IDX_D_DATA, 8'ha5);
    e_en <= 3'b111;
    e_val <= 3'b101;
    bus(1'b1, `PCDE_IDX_E_DIR, 8'h06);
    bus(1'b1, `PCDE_IDX_E_DATA, 8'h01);
    tick(3);
    chk({e_oe, e_out[0]}, 4'h3);
    rd(`PCDE_IDX_E_DATA, 8'h00);
    bus(1'b1, `PCDE_IDX_ANALOG, 8'h07);
    tick(3);
    rd(`PCDE_IDX_E_DATA, 8'h05);
    $display("port d and e done");
    e_val <= 3'b111;
    bus(1'b1, `PCDE_IDX_E_DIR, 8'hff);
    d_en <= 8'hff;
    d_val <= 8'h3c;
    tick(4);
    rd(`PCDE_IDX_E_DIR, 8'h37);
    tick(0);
    chk({o_mode, o_d_ttl, o_e_ttl}, 3'b111);
    chk(d_oe, 8'h00);
    chk(pd, 8'h3c);
    @(posedge i_clk_sys);
    e_val <= 3'b010;
    tick(4);
    chk(d_oe, 8'hff);
    chk({o_cs_n, o_wr_n, o_rd_n}, 3'b010);
    @(posedge i_clk_sys);
    e_val <= 3'b111;
    bus(1'b1, `PCDE_IDX_E_DIR, 8'h07);
    tick(3);
    chk({o_mode, o_cs_n, o_wr_n, o_rd_n}, 4'h7);
    $display("parallel mode done");
    give_verdict;
  end
endmodule // pcde_io_tb

// ===== verilog/pcde_cfg.svh
// constants for the port c/d/e io block: offsets, field positions, reset values
`ifndef PCDE_CFG_SVH
`define PCDE_CFG_SVH
// register indices as printed; byte address is four times the index
`define PCDE_IDX_C_DATA 8'h07
`define PCDE_IDX_D_DATA 8'h08
`define PCDE_IDX_E_DATA 8'h09
`define PCDE_IDX_C_DIR 8'h87
`define PCDE_IDX_D_DIR 8'h88
`define PCDE_IDX_E_DIR 8'h89
`define PCDE_IDX_SER_STAT 8'h94
`define PCDE_IDX_ANALOG 8'h9f
// reset values
`define PCDE_RST_C_DIR 8'hff
`define PCDE_RST_D_DIR 8'hff
`define PCDE_RST_E_DIR 8'h07
`define PCDE_RST_ANALOG 4'h0
// field positions in the port e direction register
`define PCDE_E_IBF_BIT 7
`define PCDE_E_OBF_BIT 6
`define PCDE_E_OVF_BIT 5
`define PCDE_E_MODE_BIT 4
// smbus level select in the serial status register
`define PCDE_SER_SMBUS_BIT 6
// analog config values leaving port e digital
`define PCDE_ANALOG_DIG_A 4'h6
`define PCDE_ANALOG_DIG_B 4'h7
`endif

// ===== verilog/pcde_io.sv
// port c/d/e general purpose io block with ahb-lite register access
// Summary of operation
// [R1] port c is eight bidirectional bits; direction one makes the pin an input
// [R2] direction zero drives the pin from its output latch
// [R3] in i2c mode serial status bit 6 picks smbus levels on c4:c3
// [R4] an enabled peripheral may force a port c pin to output or input
// [R5] software avoids read-modify-write of port c direction during overrides
// [R6] per-pin select picks latch or peripheral; peripheral oe counts only then
// [R7] port c alternates: timer one, capture channels, serial, usart pins
// [R8] data latches undefined at power-on, kept otherwise; c/d direction reset ones
// [R9] port d is eight bits, each with its own direction bit
// [R10] port e direction bit 4 makes port d a microprocessor port, ttl inputs
// [R11] in that mode port d pin n carries parallel data bit n
// [R12] port e direction: flags 7:5, mode 4, bit 3 zero, directions 2:0
// [R13] port e has three pins each with its own direction bit
// [R14] in parallel mode port e pins are the control inputs, ttl buffers
// [R15] software sets e directions and digital analog config before parallel mode
// [R16] port e pins selected analog read as zero
// [R17] port e direction still controls drivers while pins are analog
// [R18] at power-on port e pins are analog and read zero
// [R19] build option removes ports d and e for the small package
// [R20] parallel mode: e0 read strobe, e1 write strobe, e2 chip select, low active
// [R21] data reads return pins; data writes update only the latch
// [R22] in parallel mode port d direction bits do not affect drivers
`timescale 1ns/1ns
`include "pcde_cfg.svh"
module pcde_io #(
  parameter bit HAS_PORT_DE = 1'b1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // port c pins
  input wire logic [7:0] i_port_c_pin,
  output logic [7:0] o_port_c_pin,
  output logic [7:0] o_port_c_oe,
  output logic [1:0] o_port_c_smbus_lvl,
  // port c peripheral sharing
  input wire logic [7:0] i_port_c_per_sel,
  input wire logic [7:0] i_port_c_per_out,
  input wire logic [7:0] i_port_c_per_oe,
  input wire logic [7:0] i_port_c_per_force_in,
  input wire logic i_serial_i2c_mode,
  output logic [7:0] o_port_c_per_in,
  // port d pins
  input wire logic [7:0] i_port_d_pin,
  output logic [7:0] o_port_d_pin,
  output logic [7:0] o_port_d_oe,
  output logic o_port_d_ttl,
  // port e pins
  input wire logic [2:0] i_port_e_pin,
  output logic [2:0] o_port_e_pin,
  output logic [2:0] o_port_e_oe,
  output logic o_port_e_ttl,
  // parallel microprocessor port view
  output logic o_par_mode,
  output logic o_par_rd_n,
  output logic o_par_wr_n,
  output logic o_par_cs_n,
  output logic [7:0] o_par_data_in
);
  import pcde_pkg::*;

  // ********************************************************
  // register state
  // ********************************************************
  pcde_byte_t c_latch_reg, d_latch_reg;
  pcde_byte_t c_dir_reg, d_dir_reg;
  logic [2:0] e_latch_reg, e_dir_reg;
  logic e_mode_reg, e_ovf_reg;
  logic smbus_sel_reg;
  logic [3:0] analog_reg;
  pcde_bus_t bus_state_reg;
  logic [7:0] bus_idx_reg;
  logic [7:0] c_sync, d_sync;
  logic [2:0] e_sync;
  logic [7:0] c_drv, c_oe_drv;
  logic e_digital;
  logic [7:0] rd_idx;
  pcde_byte_t rd_byte;
  pcde_byte_t fwd_mask;
  pcde_byte_t rd_fwd;

  // byte address to register index
  function automatic logic [7:0] addr_idx(input logic [31:0] a);
    return a[9:2];
  endfunction

  // analog config codes that keep port e digital
  function automatic logic analog_is_dig(input logic [3:0] cfg);
    return (cfg == `PCDE_ANALOG_DIG_A) || (cfg == `PCDE_ANALOG_DIG_B);
  endfunction

  // bits that a register write stores and a read gives back unchanged;
  // data registers read the pins, not the latch, so they are never forwarded
  // and their mask stays zero
  function automatic pcde_byte_t store_mask(input logic [7:0] idx);
    if (idx == `PCDE_IDX_C_DIR) begin
      return 8'hff;
    end else if (HAS_PORT_DE && idx == `PCDE_IDX_D_DIR) begin
      return 8'hff;
    end else if (HAS_PORT_DE && idx == `PCDE_IDX_E_DIR) begin
      return 8'h37;
    end else if (idx == `PCDE_IDX_SER_STAT) begin
      return 8'h40;
    end else if (idx == `PCDE_IDX_ANALOG) begin
      return 8'h0f;
    end
    return 8'h00;
  endfunction

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  pcde_sync #(.WIDTH(8)) u_sync_c (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_port_c_pin),
    .o_sync(c_sync)
  );
  pcde_sync #(.WIDTH(8)) u_sync_d (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_port_d_pin),
    .o_sync(d_sync)
  );
  pcde_sync #(.WIDTH(3)) u_sync_e (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_port_e_pin),
    .o_sync(e_sync)
  );

  // ********************************************************
  // port c output mux
  // ********************************************************
  pcde_pin_mux #(.WIDTH(8)) u_mux_c (
    .i_latch(c_latch_reg),
    .i_dir(c_dir_reg),
    .i_per_sel(i_port_c_per_sel),
    .i_per_out(i_port_c_per_out),
    .i_per_oe(i_port_c_per_oe),
    .i_per_force_in(i_port_c_per_force_in),
    .o_out(c_drv),
    .o_oe(c_oe_drv)
  );

  assign e_digital = analog_is_dig(analog_reg); // [R16]

  // ********************************************************
  // ahb-lite address phase capture
  // ********************************************************
  // zero wait states: every transfer answers with okay in its data phase
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      bus_state_reg <= PCDE_BUS_IDLE;
      bus_idx_reg <= 8'h00;
    end else if (i_hready) begin
      if (i_hsel && i_htrans[1]) begin
        bus_state_reg <= i_hwrite ? PCDE_BUS_WR : PCDE_BUS_RD;
        bus_idx_reg <= addr_idx(i_haddr);
      end else begin
        bus_state_reg <= PCDE_BUS_IDLE;
      end
    end
  end

  // ********************************************************
  // data latches
  // ********************************************************
  // latches have no reset: undefined at power-on, kept across resets
  always_ff @(posedge i_clk_sys) begin
    if (bus_state_reg == PCDE_BUS_WR) begin
      if (bus_idx_reg == `PCDE_IDX_C_DATA) begin
        c_latch_reg <= i_hwdata[7:0]; // [R8] [R21]
      end else if (HAS_PORT_DE && bus_idx_reg == `PCDE_IDX_D_DATA) begin
        d_latch_reg <= i_hwdata[7:0]; // [R19] [R21]
      end else if (HAS_PORT_DE && bus_idx_reg == `PCDE_IDX_E_DATA) begin
        e_latch_reg <= i_hwdata[2:0];
      end
    end
  end

  // ********************************************************
  // direction and control registers
  // ********************************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      c_dir_reg <= `PCDE_RST_C_DIR; // [R8]
      d_dir_reg <= `PCDE_RST_D_DIR; // [R8]
      e_dir_reg <= 3'(`PCDE_RST_E_DIR); // [R12]
      e_mode_reg <= 1'b0;
      e_ovf_reg <= 1'b0;
      smbus_sel_reg <= 1'b0;
      analog_reg <= `PCDE_RST_ANALOG; // [R18]
    end else if (bus_state_reg == PCDE_BUS_WR) begin
      if (bus_idx_reg == `PCDE_IDX_C_DIR) begin
        c_dir_reg <= i_hwdata[7:0]; // [R1]
      end else if (HAS_PORT_DE && bus_idx_reg == `PCDE_IDX_D_DIR) begin
        d_dir_reg <= i_hwdata[7:0]; // [R9]
      end else if (HAS_PORT_DE && bus_idx_reg == `PCDE_IDX_E_DIR) begin
        e_dir_reg <= i_hwdata[2:0]; // [R13]
        e_mode_reg <= i_hwdata[`PCDE_E_MODE_BIT]; // [R10]
        e_ovf_reg <= i_hwdata[`PCDE_E_OVF_BIT]; // [R12]
      end else if (bus_idx_reg == `PCDE_IDX_SER_STAT) begin
        smbus_sel_reg <= i_hwdata[`PCDE_SER_SMBUS_BIT]; // [R3]
      end else if (bus_idx_reg == `PCDE_IDX_ANALOG) begin
        analog_reg <= i_hwdata[3:0];
      end
    end
  end

  // ********************************************************
  // read data
  // ********************************************************
  // the read is decoded at the address phase and registered, so hrdata comes
  // straight from a flop with no wait state; pins are already two edges old,
  // so sampling them one edge earlier than the data phase changes nothing
  assign rd_idx = addr_idx(i_haddr);

  always_comb begin
    rd_byte = 8'h00;
    if (rd_idx == `PCDE_IDX_C_DATA) begin
      rd_byte = c_sync; // [R21]
    end else if (HAS_PORT_DE && rd_idx == `PCDE_IDX_D_DATA) begin
      rd_byte = d_sync; // [R21]
    end else if (HAS_PORT_DE && rd_idx == `PCDE_IDX_E_DATA) begin
      rd_byte = {5'h00, e_digital ? e_sync : 3'h0}; // [R16] [R18]
    end else if (rd_idx == `PCDE_IDX_C_DIR) begin
      rd_byte = c_dir_reg;
    end else if (HAS_PORT_DE && rd_idx == `PCDE_IDX_D_DIR) begin
      rd_byte = d_dir_reg; // [R19]
    end else if (HAS_PORT_DE && rd_idx == `PCDE_IDX_E_DIR) begin
      // buffer-full flags are held clear: the handshake is not built here
      rd_byte = {2'b00, e_ovf_reg, e_mode_reg, 1'b0, e_dir_reg}; // [R12]
    end else if (rd_idx == `PCDE_IDX_SER_STAT) begin
      rd_byte = {1'b0, smbus_sel_reg, 6'h00};
    end else if (rd_idx == `PCDE_IDX_ANALOG) begin
      rd_byte = {4'h0, analog_reg};
    end
  end

  // a write whose data phase ends at this edge lands only now; without this
  // forward a back-to-back read of the same register would return stale bits
  always_comb begin
    fwd_mask = 8'h00;
    if (bus_state_reg == PCDE_BUS_WR && bus_idx_reg == rd_idx) begin
      fwd_mask = store_mask(rd_idx);
    end
    rd_fwd = (rd_byte & ~fwd_mask) | (i_hwdata[7:0] & fwd_mask);
  end

  // ahb outputs: zero-wait okay, read data only during a read data phase;
  // ready and response are flops too, so every block output is registered,
  // and ready already stands high while reset is held
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
        o_hrdata <= {24'h000000, rd_fwd};
      end else begin
        o_hrdata <= 32'h00000000;
      end
    end
  end

  // ********************************************************
  // port c pin drive
  // ********************************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_port_c_pin <= 8'h00;
      o_port_c_oe <= 8'h00;
      o_port_c_smbus_lvl <= 2'b00;
      o_port_c_per_in <= 8'h00;
    end else begin
      o_port_c_pin <= c_drv; // [R2] [R6] [R7]
      o_port_c_oe <= c_oe_drv; // [R1] [R4]
      o_port_c_smbus_lvl <= {2{i_serial_i2c_mode & smbus_sel_reg}}; // [R3]
      o_port_c_per_in <= c_sync; // [R7]
    end
  end

  // ********************************************************
  // port d and e pin drive
  // ********************************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !HAS_PORT_DE) begin // [R19]
      o_port_d_pin <= 8'h00;
      o_port_d_oe <= 8'h00;
      o_port_d_ttl <= 1'b0;
      o_port_e_pin <= 3'h0;
      o_port_e_oe <= 3'h0;
      o_port_e_ttl <= 1'b0;
    end else begin
      o_port_d_pin <= d_latch_reg; // [R11]
      if (e_mode_reg) begin
        // external bus drives d; device drives only during a selected read
        o_port_d_oe <= {8{~e_sync[0] & ~e_sync[2]}}; // [R20] [R22]
      end else begin
        o_port_d_oe <= ~d_dir_reg; // [R9]
      end
      o_port_d_ttl <= e_mode_reg; // [R10]
      o_port_e_pin <= e_latch_reg;
      o_port_e_oe <= ~e_dir_reg; // [R13] [R17]
      o_port_e_ttl <= e_mode_reg; // [R14]
    end
  end

  // ********************************************************
  // parallel port view
  // ********************************************************
  // strobes idle high outside the mode so nothing downstream sees a cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !HAS_PORT_DE) begin
      o_par_mode <= 1'b0;
      o_par_rd_n <= 1'b1;
      o_par_wr_n <= 1'b1;
      o_par_cs_n <= 1'b1;
      o_par_data_in <= 8'h00;
    end else begin
      o_par_mode <= e_mode_reg; // [R10]
      o_par_rd_n <= e_mode_reg ? e_sync[0] : 1'b1; // [R14] [R20]
      o_par_wr_n <= e_mode_reg ? e_sync[1] : 1'b1; // [R20]
      o_par_cs_n <= e_mode_reg ? e_sync[2] : 1'b1; // [R20]
      o_par_data_in <= d_sync; // [R11]
    end
  end
endmodule // pcde_io

// ===== verilog/pcde_pin_mux.sv
// per-pin output mux: port latch or peripheral, with direction override
`timescale 1ns/1ns
module pcde_pin_mux #(
  parameter int WIDTH = 8
) (
  // port side
  input wire logic [WIDTH-1:0] i_latch,
  input wire logic [WIDTH-1:0] i_dir,
  // peripheral side
  input wire logic [WIDTH-1:0] i_per_sel,
  input wire logic [WIDTH-1:0] i_per_out,
  input wire logic [WIDTH-1:0] i_per_oe,
  input wire logic [WIDTH-1:0] i_per_force_in,
  // pin drive
  output logic [WIDTH-1:0] o_out,
  output logic [WIDTH-1:0] o_oe
);
  // select picks peripheral data; peripheral oe only counts while selected
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      o_out[i] = i_per_sel[i] ? i_per_out[i] : i_latch[i]; // [R6]
      if (i_per_force_in[i]) begin
        o_oe[i] = 1'b0; // [R4]
      end else if (i_per_sel[i]) begin
        o_oe[i] = i_per_oe[i]; // [R4] [R6]
      end else begin
        o_oe[i] = ~i_dir[i]; // [R1] [R2]
      end
    end
  end
endmodule // pcde_pin_mux

// ===== verilog/pcde_pkg.sv
// types shared by the port c/d/e io block
package pcde_pkg;
  typedef enum logic [1:0] {
    PCDE_BUS_IDLE = 2'b00,
    PCDE_BUS_WR = 2'b01,
    PCDE_BUS_RD = 2'b10
  } pcde_bus_t;
  typedef logic [7:0] pcde_byte_t;
endpackage

// ===== verilog/pcde_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
module pcde_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // async input and its synchronised copy
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  // first stage feeds only the second
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule // pcde_sync
